// ---- dvopt_map.svh ----
/*
 option word map: field positions, reset values, register offsets.
 assumes inclusion by the option block and its package users.
*/
`ifndef DVOPT_MAP_SVH
`define DVOPT_MAP_SVH
`define DVOPT_WORD_W 24
`define DVOPT_BIT_REFLOC 4
`define DVOPT_BIT_KEYWIPE_OFF 3
`define DVOPT_BIT_PIN_OFF 2
`define DVOPT_BIT_CMPLOC 1
`define DVOPT_IMPL_MASK 24'h00001e
`define DVOPT_ERASED 24'hffffff
`define DVOPT_ADDR_W 4
`define DVOPT_OFS_WORD 4'h0
`define DVOPT_OFS_PROG 4'h4
`define DVOPT_OFS_STAT 4'h8
`endif

// ---- dvopt_pkg.sv ----
/*
 types for the option word block.
 assumes dvopt_map.svh is on the include path.
*/
`include "dvopt_map.svh"
package dvopt_pkg;
    typedef logic [`DVOPT_WORD_W-1:0] dvopt_word_type;
    typedef struct packed {
        logic reference_location_select;
        logic key_wipe_on_intrusion_off;
        logic intrusion_pin_off;
        logic comparator_input_location_select;
    } dvopt_settings_type;
    typedef struct packed {
        logic comparator1_c_input;
        logic comparator2_c_input;
        logic comparator3_c_input;
    } dvopt_cmp_type;
    typedef enum logic [2:0] {
        DVOPT_ST_LOAD = 3'b001,
        DVOPT_ST_RUN = 3'b010,
        DVOPT_ST_HOLD = 3'b100
    } dvopt_state_type;
endpackage : dvopt_pkg

// ---- dvopt_sync.sv ----
/*
 two flop synchroniser for pin inputs.
 assumes one clock, synchronous active high reset.
*/
module dvopt_sync
    import dvopt_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // data
    input wire logic d_in,
    output logic d_out
);
    logic s1_reg;
    logic s2_reg;
    logic s1_next;
    logic s2_next;
    always_comb begin
        s1_next = d_in;
        s2_next = s1_reg;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end
    assign d_out = s2_reg;
endmodule : dvopt_sync

// ---- dvopt_config.sv ----
/*
 option word storage and decode: program-once bits, reference pair and
 comparator pin routing, intrusion input gating and key wipe request.
 assumes a plain register port on mclk; pins arrive asynchronously.
*/
// Local design decisions: the placing of the registers and strobed register access.
`include "dvopt_map.svh"
module dvopt_config
    import dvopt_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [`DVOPT_ADDR_W-1:0] reg_addr,
    input wire logic [`DVOPT_WORD_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DVOPT_WORD_W-1:0] reg_rdata,
    // reference pin routing
    output logic ref_high_in,
    output logic ref_low_in,
    input wire logic default_ref_high_pin,
    input wire logic default_ref_low_pin,
    input wire logic alt_ref_high_pin,
    input wire logic alt_ref_low_pin,
    // comparator pin routing
    input wire dvopt_cmp_type cmp_default_pins,
    input wire logic shared_comparator_pin,
    output dvopt_cmp_type cmp_inputs,
    // intrusion
    input wire logic intrusion_input_n,
    output logic intrusion_event,
    output logic key_wipe,
    // settings in force
    output dvopt_settings_type settings
);
    dvopt_word_type nv_reg = `DVOPT_ERASED;
    dvopt_word_type nv_next;
    logic [3:0] done_reg = 4'h0;
    logic [3:0] done_next;
    dvopt_settings_type set_reg, set_next;
    dvopt_state_type st_reg, st_next;
    logic [`DVOPT_WORD_W-1:0] rdata_reg, rdata_next;
    logic ref_hi_reg, ref_hi_next, ref_lo_reg, ref_lo_next;
    dvopt_cmp_type cmp_reg, cmp_next;
    logic intr_prev_reg, intr_prev_next;
    logic ev_reg, ev_next, wipe_reg, wipe_next;
    logic intr_s;
    dvopt_word_type view;
    logic [7:0] pin_raw;
    logic [7:0] pin_s;
    dvopt_sync u_intr_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .d_in(intrusion_input_n),
        .d_out(intr_s)
    );
    // routed pins brought onto mclk
    assign pin_raw = {alt_ref_low_pin, alt_ref_high_pin, default_ref_low_pin,
                      default_ref_high_pin, shared_comparator_pin,
                      cmp_default_pins};
    for (genvar g = 0; g < 8; g++) begin : g_pin_sync
        dvopt_sync u_pin_sync (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .d_in(pin_raw[g]),
            .d_out(pin_s[g])
        );
    end
    // word as read: unimplemented bits forced to 1
    assign view = nv_reg | ~`DVOPT_IMPL_MASK;
    // storage, program once per bit
    always_comb begin
        nv_next = nv_reg;
        done_next = done_reg;
        if (reg_wr && reg_addr == `DVOPT_OFS_PROG) begin
            for (int i = 0; i < 4; i++) begin
                if (!done_reg[i]) begin
                    nv_next[i+1] = reg_wdata[i+1];
                    done_next[i] = 1'b1;
                end
            end
        end
    end
    // load at reset, then hold
    always_comb begin
        st_next = st_reg;
        set_next = set_reg;
        unique case (st_reg)
            DVOPT_ST_LOAD: begin
                set_next = {view[`DVOPT_BIT_REFLOC],
                            view[`DVOPT_BIT_KEYWIPE_OFF],
                            view[`DVOPT_BIT_PIN_OFF],
                            view[`DVOPT_BIT_CMPLOC]};
                st_next = DVOPT_ST_RUN;
            end
            DVOPT_ST_RUN: st_next = DVOPT_ST_HOLD;
            DVOPT_ST_HOLD: st_next = DVOPT_ST_HOLD;
            default: st_next = DVOPT_ST_LOAD;
        endcase
    end
    // read port
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            if (reg_addr == `DVOPT_OFS_WORD) rdata_next = view;
            else if (reg_addr == `DVOPT_OFS_STAT)
                rdata_next = {{(`DVOPT_WORD_W-7){1'b0}}, st_reg, done_reg};
        end
    end
    // routing and intrusion
    always_comb begin
        ref_hi_next = set_reg.reference_location_select ?
                      pin_s[6] : pin_s[4];
        ref_lo_next = set_reg.reference_location_select ?
                      pin_s[7] : pin_s[5];
        cmp_next = set_reg.comparator_input_location_select ?
                   pin_s[2:0] : {3{pin_s[3]}};
        intr_prev_next = intr_s;
        ev_next = st_reg == DVOPT_ST_HOLD && !set_reg.intrusion_pin_off
                  && intr_prev_reg && !intr_s;
        wipe_next = ev_next && !set_reg.key_wipe_on_intrusion_off;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_reg <= DVOPT_ST_LOAD;
            set_reg <= 4'hf;
            rdata_reg <= '0;
            ref_hi_reg <= 1'b0;
            ref_lo_reg <= 1'b0;
            cmp_reg <= 3'h0;
            intr_prev_reg <= 1'b1;
            ev_reg <= 1'b0;
            wipe_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            set_reg <= set_next;
            rdata_reg <= rdata_next;
            ref_hi_reg <= ref_hi_next;
            ref_lo_reg <= ref_lo_next;
            cmp_reg <= cmp_next;
            intr_prev_reg <= intr_prev_next;
            ev_reg <= ev_next;
            wipe_reg <= wipe_next;
        end
    end
    // non-volatile store: not cleared by reset
    always_ff @(posedge mclk) begin
        nv_reg <= nv_next;
        done_reg <= done_next;
    end
    assign reg_rdata = rdata_reg;
    assign cmp_inputs = cmp_reg;
    assign intrusion_event = ev_reg;
    assign key_wipe = wipe_reg;
    assign settings = set_reg;
    assign ref_high_in = ref_hi_reg;
    assign ref_low_in = ref_lo_reg;

    property p_unimpl_ones;
        @(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == `DVOPT_OFS_WORD |=>
            (reg_rdata | `DVOPT_IMPL_MASK) == `DVOPT_ERASED;
    endproperty
    a_unimpl_ones: assert property (p_unimpl_ones)
        else $error("unimplemented option bit read as 0");
    property p_once;
        @(posedge mclk) disable iff (sys_rst)
        done_reg[0] |=> nv_reg[1] == $past(nv_reg[1]);
    endproperty
    a_once: assert property (p_once)
        else $error("option bit changed after programming");
    property p_hold;
        @(posedge mclk) disable iff (sys_rst)
        st_reg == DVOPT_ST_HOLD |=> $stable(set_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("settings changed while running");
    property p_pin_off;
        @(posedge mclk) disable iff (sys_rst)
        set_reg.intrusion_pin_off |-> ##1 !ev_reg;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("intrusion event with pin disabled");
    property p_wipe;
        @(posedge mclk) disable iff (sys_rst)
        ev_reg |-> key_wipe == !set_reg.key_wipe_on_intrusion_off;
    endproperty
    a_wipe: assert property (p_wipe)
        else $error("key wipe does not follow option");
    property p_cmp;
        @(posedge mclk) disable iff (sys_rst)
        st_reg == DVOPT_ST_HOLD && !set_reg.comparator_input_location_select
        |=> cmp_reg == {3{$past(shared_comparator_pin, 3)}};
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("comparator inputs not on shared pin");
    property p_ref;
        @(posedge mclk) disable iff (sys_rst)
        st_reg == DVOPT_ST_HOLD && set_reg.reference_location_select
        |=> ref_hi_reg == $past(alt_ref_high_pin, 3);
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference not on alternate pin");
    property p_ref_default;
        @(posedge mclk) disable iff (sys_rst)
        st_reg == DVOPT_ST_HOLD && !set_reg.reference_location_select
        |=> ref_lo_reg == $past(default_ref_low_pin, 3);
    endproperty
    a_ref_default: assert property (p_ref_default)
        else $error("reference not on default pin");
    property p_load;
        @(posedge mclk) disable iff (sys_rst)
        st_reg == DVOPT_ST_LOAD |=> st_reg == DVOPT_ST_RUN ##1
            st_reg == DVOPT_ST_HOLD;
    endproperty
    a_load: assert property (p_load)
        else $error("load sequence broken");
endmodule : dvopt_config

// ---- dvopt_config_test.sv ----
/*
 self-checking bench for the option word block: register reads and
 program-once writes, settings after reset, comparator routing, intrusion.
 assumes dvopt_pkg and dvopt_map.svh compiled first; one clock, mclk.
*/
`include "dvopt_map.svh"
module dvopt_config_test
    import dvopt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // clock and reset
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    // register port
    logic [`DVOPT_ADDR_W-1:0] reg_addr = '0;
    logic [`DVOPT_WORD_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [`DVOPT_WORD_W-1:0] reg_rdata;
    // pins
    logic [3:0] ref_pins = 4'h6;
    logic ref_high;
    logic ref_low;
    dvopt_cmp_type cmp_default_pins = 3'b101;
    logic shared_comparator_pin = 1'b0;
    dvopt_cmp_type cmp_inputs;
    logic intrusion_input_n = 1'b1;
    logic intrusion_event;
    logic key_wipe;
    dvopt_settings_type settings;
    int bad_count = 0;
    int n_checks = 0;

    always #10 mclk = ~mclk;

    dvopt_config i_dut (
        .mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ref_high_in(ref_high), .ref_low_in(ref_low),
        .default_ref_high_pin(ref_pins[0]),
        .default_ref_low_pin(ref_pins[1]),
        .alt_ref_high_pin(ref_pins[2]), .alt_ref_low_pin(ref_pins[3]),
        .cmp_default_pins(cmp_default_pins),
        .shared_comparator_pin(shared_comparator_pin),
        .cmp_inputs(cmp_inputs),
        .intrusion_input_n(intrusion_input_n),
        .intrusion_event(intrusion_event), .key_wipe(key_wipe),
        .settings(settings)
    );

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic do_reset(input int n);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (n) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : do_reset

    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [23:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // drives the pin low for ten cycles, counts event pulses and wipes
    task automatic intrude(output int hits, output int wipes);
        hits = 0;
        wipes = 0;
        @(posedge mclk);
        intrusion_input_n <= 1'b0;
        repeat (10) begin
            @(posedge mclk);
            #1;
            if (intrusion_event === 1'b1) hits++;
            if (key_wipe === 1'b1) wipes++;
            if (key_wipe !== intrusion_event) wipes += 100;
        end
        intrusion_input_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : intrude

    initial begin
        #100us;
        bad_count++;
        end_sim();
    end

    initial begin
        logic [23:0] d;
        int h;
        int w;
        do_reset(20);
        chk(settings, 4'hf);
        rd(`DVOPT_OFS_WORD, d);
        chk(d, 24'hffffff);
        @(posedge mclk);
        #1 chk(reg_rdata, 24'h0);
        rd(4'hc, d);
        chk(d, 24'h0);
        rd(`DVOPT_OFS_STAT, d);
        chk(d, 24'h000040);
        chk(cmp_inputs, 3'b101);
        chk({ref_high, ref_low}, 2'b10);
        intrude(h, w);
        chk(24'(h), 24'h0);
        chk(24'(w), 24'h0);
        wr(`DVOPT_OFS_PROG, 24'hffffe1);
        rd(`DVOPT_OFS_WORD, d);
        chk(d, 24'hffffe1);
        rd(`DVOPT_OFS_STAT, d);
        chk(d, 24'h00004f);
        wr(`DVOPT_OFS_PROG, 24'hfffff1);
        rd(`DVOPT_OFS_WORD, d);
        chk(d, 24'hffffe1);
        chk(settings, 4'hf);
        do_reset(2);
        chk(settings, 4'h0);
        shared_comparator_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk(cmp_inputs, 3'b111);
        chk({ref_high, ref_low}, 2'b01);
        shared_comparator_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        #1 chk(cmp_inputs, 3'b000);
        intrude(h, w);
        chk(24'(h), 24'h1);
        chk(24'(w), 24'h1);
        rd(`DVOPT_OFS_WORD, d);
        chk(d, 24'hffffe1);
        chk(settings, 4'h0);
        end_sim();
    end
endmodule : dvopt_config_test
